// file: logic/dfm_pkg.sv
package dfm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CLK_NS = 10;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] OFF_HIST_SEL = 8'h14;
  localparam logic [7:0] OFF_HIST_DATA = 8'h18;
  localparam logic [7:0] OFF_HIST_CNT = 8'h1C;
  // CTRL fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_EXT_LSB = 4;
  localparam int CTRL_HOSTRST = 8;
  localparam logic [3:0] SEL_ON = 4'h1;
  localparam logic [3:0] SEL_RST = 4'h0;
  // Interrupt event bits
  localparam int IRQ_N = 3;
  localparam int IRQ_ALM_SET = 0;
  localparam int IRQ_WARN_SET = 1;
  localparam int IRQ_ALM_CLR = 2;
  // Fault numbers and details
  localparam logic [7:0] ALM_UNDERVOLT = 8'h10;
  localparam logic [7:0] ALM_SWITCH = 8'h11;
  localparam logic [7:0] ALM_RAM = 8'h12;
  localparam logic [7:0] ALM_CLOCK = 8'h13;
  localparam logic [7:0] ALM_PROCESS = 8'h14;
  localparam logic [7:0] ALM_NVMEM = 8'h15;
  localparam logic [7:0] ALM_PARAM = 8'h37;
  localparam logic [7:0] WARN_FIRST = 8'h91;
  localparam logic [7:0] WARN_LAST = 8'hF3;
  localparam logic [7:0] WARN_TOUGH = 8'hF0;
  localparam logic [3:0] DET_CTRL_SUPPLY = 4'h1;
  localparam logic [3:0] DET_RAM_NOCODE = 4'h6;
  localparam logic [3:0] DET_PROC_NOCODE = 4'hB;
  localparam logic [3:0] CODE_UNDERVOLT = 4'h2;
  localparam logic [3:0] CODE_ZERO = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {STOP_DB, STOP_EDB, STOP_SD} dfm_stop_t;

  typedef struct packed {
    logic valid;
    logic [7:0] number;
    logic [3:0] detail;
  } dfm_fault_t;

  typedef struct packed {
    logic codeValid;
    logic [3:0] code;
    dfm_stop_t stop;
    logic resetOk;
    logic record;
  } dfm_info_t;
endpackage

// file: logic/dfm_fault_manager.sv
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module dfm_fault_manager #(
  parameter int unsigned DECEL_NS = 1000000,
  parameter int HIST_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [dfm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dfm_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dfm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dfm_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dfm_pkg::dfm_fault_t faultEvt,
  input wire logic alarmCause,
  input wire logic warnCause,
  input wire logic panelAlarmShown,
  input wire logic faultClearInput,
  input wire logic panelSetKey,
  input wire logic driveEnableInput,
  input wire logic extUnitPresent,
  output logic faultIndicator,
  output logic faultCodeBit0,
  output logic faultCodeBit1,
  output logic faultCodeBit2,
  output logic faultCodeBit3,
  output logic faultCodeValid,
  output logic decelCmd,
  output logic brakeCmd,
  output logic irq
);
  localparam int unsigned DECEL_CYC_RAW = (DECEL_NS + dfm_pkg::CLK_NS - 1) / dfm_pkg::CLK_NS;
  localparam int unsigned DECEL_CYC = (DECEL_CYC_RAW < 1) ? 1 : DECEL_CYC_RAW;
  localparam int HW = (HIST_DEPTH > 1) ? $clog2(HIST_DEPTH) : 1;
  localparam logic [HW:0] HIST_FULL = HIST_DEPTH[HW:0];

  typedef enum logic [1:0] {ST_RUN, ST_DECEL, ST_BRAKE} dfm_state_t;

  // Pin synchronisers: clear, panel key, drive enable, extension strap
  logic [3:0] pinMeta_reg;
  logic [3:0] pinSync_reg;
  logic [1:0] pinPrev_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_reg <= 4'h0;
      pinSync_reg <= 4'h0;
      pinPrev_reg <= 2'h0;
    end else if (ce) begin
      pinMeta_reg <= {extUnitPresent, driveEnableInput, panelSetKey, faultClearInput};
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg[1:0];
    end
  end
  logic clrEdge;
  logic keyEdge;
  assign clrEdge = pinSync_reg[0] && !pinPrev_reg[0];
  assign keyEdge = pinSync_reg[1] && !pinPrev_reg[1];

  function automatic dfm_pkg::dfm_info_t alarmInfo(input logic [7:0] num, input logic [3:0] det);
    dfm_pkg::dfm_info_t r;
    r.codeValid = 1'b0;
    r.code = dfm_pkg::CODE_ZERO;
    r.stop = dfm_pkg::STOP_DB;
    r.resetOk = 1'b0;
    r.record = (num != dfm_pkg::ALM_PARAM);
    case (num)
      dfm_pkg::ALM_UNDERVOLT: begin
        r.codeValid = 1'b1;
        r.code = dfm_pkg::CODE_UNDERVOLT;
        r.stop = (det == dfm_pkg::DET_CTRL_SUPPLY) ? dfm_pkg::STOP_EDB : dfm_pkg::STOP_SD;
        r.resetOk = 1'b1;
      end
      dfm_pkg::ALM_SWITCH: r.codeValid = 1'b0;
      dfm_pkg::ALM_RAM: r.codeValid = (det != dfm_pkg::DET_RAM_NOCODE);
      dfm_pkg::ALM_CLOCK: r.codeValid = 1'b1;
      dfm_pkg::ALM_PROCESS: r.codeValid = (det != dfm_pkg::DET_PROC_NOCODE);
      dfm_pkg::ALM_NVMEM: r.codeValid = 1'b1;
      default: r.resetOk = 1'b1;
    endcase
    return r;
  endfunction

  // Register file state
  logic [3:0] codeSel_reg;
  logic [3:0] extSel_reg;
  logic hostReset_reg;
  localparam int IRQ_N_W = dfm_pkg::IRQ_N;
  logic [IRQ_N_W-1:0] irqStat_reg;
  logic [IRQ_N_W-1:0] irqEn_reg;
  logic [HW-1:0] histSel_reg;

  // AXI4-Lite write channel
  logic awHave_reg;
  logic wHave_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic wrFire;
  logic wrMapped;
  assign wrFire = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign wrMapped = (awAddr_reg == dfm_pkg::OFF_CTRL) || (awAddr_reg == dfm_pkg::OFF_IRQ_CLR) ||
                    (awAddr_reg == dfm_pkg::OFF_IRQ_EN) || (awAddr_reg == dfm_pkg::OFF_HIST_SEL);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dfm_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awready && s_axi_awvalid) begin
        awAddr_reg <= s_axi_awaddr;
        awHave_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHave_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? dfm_pkg::RESP_OKAY : dfm_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control register and host reset command
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      codeSel_reg <= dfm_pkg::SEL_RST;
      extSel_reg <= dfm_pkg::SEL_RST;
      hostReset_reg <= 1'b0;
      irqEn_reg <= '0;
      histSel_reg <= '0;
    end else if (ce) begin
      hostReset_reg <= 1'b0;
      if (wrFire && awAddr_reg == dfm_pkg::OFF_CTRL) begin
        if (wStrb_reg[0]) begin
          codeSel_reg <= wData_reg[dfm_pkg::CTRL_SEL_LSB +: 4];
          extSel_reg <= wData_reg[dfm_pkg::CTRL_EXT_LSB +: 4];
        end
        if (wStrb_reg[1]) begin
          hostReset_reg <= wData_reg[dfm_pkg::CTRL_HOSTRST];
        end
      end
      if (wrFire && awAddr_reg == dfm_pkg::OFF_IRQ_EN && wStrb_reg[0]) begin
        irqEn_reg <= wData_reg[IRQ_N_W-1:0];
      end
      if (wrFire && awAddr_reg == dfm_pkg::OFF_HIST_SEL && wStrb_reg[0]) begin
        histSel_reg <= wData_reg[HW-1:0];
      end
    end
  end

  // Alarm latch, code outputs and indicator
  dfm_pkg::dfm_info_t evtInfo;
  dfm_pkg::dfm_info_t curInfo_reg;
  logic alarmActive_reg;
  logic [7:0] alarmNum_reg;
  logic [3:0] alarmDet_reg;
  logic evtIsWarn;
  logic alarmSet;
  logic resetReq;
  logic alarmClr;
  logic ext4;
  logic sel3;
  assign evtInfo = alarmInfo(faultEvt.number, faultEvt.detail);
  assign evtIsWarn = (faultEvt.number >= dfm_pkg::WARN_FIRST) &&
                     (faultEvt.number <= dfm_pkg::WARN_LAST);
  assign alarmSet = faultEvt.valid && !evtIsWarn && !alarmActive_reg;
  assign resetReq = clrEdge || (keyEdge && panelAlarmShown) || hostReset_reg;
  assign alarmClr = alarmActive_reg && resetReq && !alarmCause && curInfo_reg.resetOk;
  assign ext4 = pinSync_reg[3] && (extSel_reg == dfm_pkg::SEL_ON);
  assign sel3 = (codeSel_reg == dfm_pkg::SEL_ON);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alarmActive_reg <= 1'b0;
      alarmNum_reg <= 8'h00;
      alarmDet_reg <= 4'h0;
      curInfo_reg <= '0;
      faultIndicator <= 1'b1;
      {faultCodeBit3, faultCodeBit2, faultCodeBit1, faultCodeBit0} <= dfm_pkg::CODE_ZERO;
      faultCodeValid <= 1'b0;
    end else if (ce) begin
      if (alarmSet) begin
        alarmActive_reg <= 1'b1;
        alarmNum_reg <= faultEvt.number;
        alarmDet_reg <= faultEvt.detail;
        curInfo_reg <= evtInfo;
        faultIndicator <= 1'b0;
        faultCodeValid <= evtInfo.codeValid && (ext4 || sel3);
        faultCodeBit0 <= evtInfo.codeValid && (ext4 || sel3) && evtInfo.code[0];
        faultCodeBit1 <= evtInfo.codeValid && (ext4 || sel3) && evtInfo.code[1];
        faultCodeBit2 <= evtInfo.codeValid && (ext4 || sel3) && evtInfo.code[2];
        faultCodeBit3 <= evtInfo.codeValid && ext4 && evtInfo.code[3];
      end else if (alarmClr) begin
        alarmActive_reg <= 1'b0;
        faultIndicator <= 1'b1;
        {faultCodeBit3, faultCodeBit2, faultCodeBit1, faultCodeBit0} <= dfm_pkg::CODE_ZERO;
        faultCodeValid <= 1'b0;
      end
    end
  end

  // Warnings: self-clearing once the cause drops, new event wins
  logic warnActive_reg;
  logic [7:0] warnNum_reg;
  logic warnSet;
  assign warnSet = faultEvt.valid && evtIsWarn;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      warnActive_reg <= 1'b0;
      warnNum_reg <= 8'h00;
    end else if (ce) begin
      if (warnSet) begin
        warnActive_reg <= 1'b1;
        warnNum_reg <= faultEvt.number;
      end else if (!warnCause) begin
        warnActive_reg <= 1'b0;
      end
    end
  end

  // Stop sequencing
  dfm_state_t state_reg;
  logic [31:0] decelCnt_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_RUN;
      decelCnt_reg <= 32'h0000_0000;
      decelCmd <= 1'b0;
      brakeCmd <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_RUN: begin
          if (alarmSet && evtInfo.stop == dfm_pkg::STOP_SD) begin
            state_reg <= ST_DECEL;
            decelCnt_reg <= 32'h0000_0000;
            decelCmd <= 1'b1;
          end else if (alarmSet) begin
            state_reg <= ST_BRAKE;
            brakeCmd <= 1'b1;
          end
        end
        ST_DECEL: begin
          if (alarmClr) begin
            state_reg <= ST_RUN;
            decelCmd <= 1'b0;
          end else if (decelCnt_reg == DECEL_CYC - 1) begin
            state_reg <= ST_BRAKE;
            decelCmd <= 1'b0;
            brakeCmd <= 1'b1;
          end else begin
            decelCnt_reg <= decelCnt_reg + 32'h0000_0001;
          end
        end
        ST_BRAKE: begin
          if (alarmClr) begin
            state_reg <= ST_RUN;
            brakeCmd <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_RUN;
          decelCmd <= 1'b0;
          brakeCmd <= 1'b0;
        end
      endcase
    end
  end

  // Fault history, newest entry at selection 0
  logic [11:0] histMem [HIST_DEPTH];
  logic [HW-1:0] histWr_reg;
  logic [HW:0] histCnt_reg;
  logic histPush;
  logic [HW-1:0] histRdIdx;
  assign histPush = (alarmSet && evtInfo.record) ||
                    (warnSet && faultEvt.number == dfm_pkg::WARN_TOUGH);
  assign histRdIdx = histWr_reg - histSel_reg - {{(HW-1){1'b0}}, 1'b1};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      histWr_reg <= '0;
      histCnt_reg <= '0;
    end else if (ce && histPush) begin
      histWr_reg <= (histWr_reg == HIST_FULL[HW-1:0] - 1'b1) ? '0 : histWr_reg + 1'b1;
      if (histCnt_reg != HIST_FULL) begin
        histCnt_reg <= histCnt_reg + 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (ce && histPush) begin
      histMem[histWr_reg] <= {faultEvt.number, faultEvt.detail};
    end
  end

  // Interrupt status, set wins over clear
  logic [IRQ_N_W-1:0] irqEvt;
  logic [IRQ_N_W-1:0] irqClr;
  assign irqEvt = {alarmClr, warnSet, alarmSet};
  assign irqClr = (wrFire && awAddr_reg == dfm_pkg::OFF_IRQ_CLR && wStrb_reg[0]) ?
                  wData_reg[IRQ_N_W-1:0] : '0;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_reg <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqEvt;
      irq <= |(irqStat_reg & irqEn_reg);
    end
  end

  // AXI4-Lite read channel
  logic [31:0] rdMux;
  logic rdMapped;
  always_comb begin
    rdMux = 32'h0000_0000;
    rdMapped = 1'b1;
    case (s_axi_araddr)
      dfm_pkg::OFF_CTRL: rdMux = {24'h00_0000, extSel_reg, codeSel_reg};
      dfm_pkg::OFF_STATUS: rdMux = {4'h0, warnNum_reg, alarmNum_reg, alarmDet_reg,
                                    2'h0, pinSync_reg[3:2], decelCmd, brakeCmd,
                                    warnActive_reg, alarmActive_reg};
      dfm_pkg::OFF_IRQ_STAT: rdMux[IRQ_N_W-1:0] = irqStat_reg;
      dfm_pkg::OFF_IRQ_CLR: rdMux = 32'h0000_0000;
      dfm_pkg::OFF_IRQ_EN: rdMux[IRQ_N_W-1:0] = irqEn_reg;
      dfm_pkg::OFF_HIST_SEL: rdMux[HW-1:0] = histSel_reg;
      dfm_pkg::OFF_HIST_DATA: rdMux[11:0] = ({1'b0, histSel_reg} < histCnt_reg) ?
                                            histMem[histRdIdx] : 12'h000;
      dfm_pkg::OFF_HIST_CNT: rdMux[HW:0] = histCnt_reg;
      default: rdMapped = 1'b0;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dfm_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdMapped ? dfm_pkg::RESP_OKAY : dfm_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  indicator_low_a: assert property (ce && alarmSet |=> !faultIndicator [*2])
    else $error("Indicator not low after alarm");
  three_bit_a: assert property (ce && alarmSet && !ext4 |=> !faultCodeBit3)
    else $error("Bit 3 driven in three-bit mode");
  warn_nocode_a: assert property (ce && warnSet && !alarmActive_reg |=> !faultCodeValid)
    else $error("Warning produced a code");
  idle_nocode_a: assert property (!alarmActive_reg |-> !faultCodeValid && !faultCodeBit0)
    else $error("Code shown with no alarm");
  code_hold_a: assert property (alarmActive_reg && !alarmClr |=>
    $stable({faultCodeValid, faultCodeBit3, faultCodeBit2, faultCodeBit1, faultCodeBit0}))
    else $error("Code changed during alarm");
  warn_clear_a: assert property (warnActive_reg && !warnCause && !warnSet && ce
    |=> !warnActive_reg) else $error("Warning did not self-clear");
  cause_hold_a: assert property (alarmActive_reg && alarmCause |=> alarmActive_reg)
    else $error("Alarm cleared with cause present");
  power_only_a: assert property (alarmActive_reg && !curInfo_reg.resetOk |=>
    alarmActive_reg) else $error("Power-cycle alarm was reset");
  decel_first_a: assert property (ce && alarmSet && evtInfo.stop == dfm_pkg::STOP_SD
    |=> decelCmd && !brakeCmd) else $error("Brake before deceleration");
  brake_now_a: assert property (ce && alarmSet && evtInfo.stop != dfm_pkg::STOP_SD
    && state_reg == ST_RUN |=> brakeCmd && !decelCmd) else $error("No immediate brake");
  undervolt_code_a: assert property (ce && alarmSet && faultEvt.number ==
    dfm_pkg::ALM_UNDERVOLT && ext4 |=> faultCodeBit1 && !faultCodeBit0 &&
    !faultCodeBit2 && !faultCodeBit3) else $error("Wrong undervoltage code");
  hist_skip_a: assert property (ce && alarmSet && faultEvt.number == dfm_pkg::ALM_PARAM
    && !warnSet |=> $stable(histCnt_reg)) else $error("Alarm 37 was recorded");
endmodule

// file: tb/dfm_ctrl_model.sv
`timescale 1ns/1ps
module dfm_ctrl_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic faultIndicator,
  input wire logic clrReq,
  output logic driveEnableInput,
  output logic faultClearInput
);
  // Drive enable dropped while an alarm is reported
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      driveEnableInput <= 1'b0;
    end else begin
      driveEnableInput <= faultIndicator;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      faultClearInput <= 1'b0;
    end else begin
      faultClearInput <= clrReq;
    end
  end
endmodule

// file: tb/tb_dfm_fault_manager.sv
`timescale 1ns/1ps
module tb_dfm_fault_manager;
  logic clk, rst_b, awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady, alarmCause, warnCause, panelAlarmShown;
  logic panelSetKey, driveEnableInput, extUnitPresent, clrReq, faultClearInput;
  logic faultIndicator, faultCodeValid, decelCmd, brakeCmd, irq, ceOn;
  wire logic [3:0] code;
  logic [7:0] awAddr, arAddr, num;
  logic [3:0] det;
  logic [31:0] wData, rData, rd;
  logic [1:0] bResp, rResp, rs;
  dfm_pkg::dfm_fault_t faultEvt;
  int err_total, total_checks, seed, i, n, m;

  dfm_fault_manager #(.DECEL_NS(100), .HIST_DEPTH(16)) dfm_fault_manager_inst (
    .clk(clk), .rst_b(rst_b), .ce(ceOn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .faultEvt(faultEvt), .alarmCause(alarmCause), .warnCause(warnCause),
    .panelAlarmShown(panelAlarmShown), .faultClearInput(faultClearInput),
    .panelSetKey(panelSetKey), .driveEnableInput(driveEnableInput),
    .extUnitPresent(extUnitPresent), .faultIndicator(faultIndicator),
    .faultCodeBit0(code[0]), .faultCodeBit1(code[1]), .faultCodeBit2(code[2]),
    .faultCodeBit3(code[3]), .faultCodeValid(faultCodeValid), .decelCmd(decelCmd),
    .brakeCmd(brakeCmd), .irq(irq));

  dfm_ctrl_model dfm_ctrl_model_inst (
    .clk(clk), .rst_b(rst_b), .faultIndicator(faultIndicator), .clrReq(clrReq),
    .driveEnableInput(driveEnableInput), .faultClearInput(faultClearInput));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tout();
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    test_done();
  endtask

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid) break;
    end
    r = bResp;
    bReady <= 1'b0;
    if (k == 50) tout();
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid) break;
    end
    d = rData;
    r = rResp;
    rReady <= 1'b0;
    if (k == 50) tout();
  endtask

  task automatic fire(input logic [7:0] nm, input logic [3:0] dt);
    @(posedge clk);
    faultEvt <= {1'b1, nm, dt};
    @(posedge clk);
    faultEvt.valid <= 1'b0;
    @(negedge clk);
  endtask

  // Source 0 clear pin, 1 panel key, 2 host command
  task automatic clearBy(input int s);
    @(posedge clk);
    clrReq <= (s == 0);
    panelSetKey <= (s == 1);
    panelAlarmShown <= (s == 1);
    if (s == 2) axiWr(dfm_pkg::OFF_CTRL, 32'h101, rs);
    repeat (4) @(posedge clk);
    clrReq <= 1'b0;
    panelSetKey <= 1'b0;
    panelAlarmShown <= 1'b0;
  endtask

  task automatic waitIdle();
    int k;
    for (k = 0; k < 30 && faultIndicator !== 1'b1; k++) @(negedge clk);
    if (k == 30) tout();
  endtask

  task automatic powerCycle();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [4:0] expCode(input logic [7:0] nm, input logic [3:0] dt,
                                         input int md);
    if (md == 0) return 5'h00;
    if (nm == 8'h10) return 5'h12;
    if (nm == 8'h11 || (nm == 8'h12 && dt == 4'h6) || (nm == 8'h14 && dt == 4'hB)) return 5'h00;
    if (nm >= 8'h12 && nm <= 8'h15) return 5'h10;
    return 5'h00;
  endfunction

  initial begin
    repeat (100000) @(posedge clk);
    tout();
  end

  initial begin
    seed = 32'h8FA9;
    err_total = 0;
    total_checks = 0;
    {rst_b, awValid, wValid, bReady, arValid, rReady, alarmCause, warnCause} = '0;
    {panelAlarmShown, panelSetKey, extUnitPresent, clrReq} = '0;
    ceOn = 1'b1;
    {awAddr, arAddr, wData} = '0;
    faultEvt = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check({faultIndicator, faultCodeValid, code, irq}, 7'h40);
    axiWr(dfm_pkg::OFF_CTRL, 32'h1, rs);
    axiRd(dfm_pkg::OFF_CTRL, rd, rs);
    check(rd, 32'h1);
    axiRd(8'h40, rd, rs);
    check(rs, dfm_pkg::RESP_SLVERR);
    check(rd, 32'h0);
    axiWr(dfm_pkg::OFF_STATUS, 32'hFF, rs);
    check(rs, dfm_pkg::RESP_SLVERR);
    axiWr(dfm_pkg::OFF_IRQ_EN, 32'h7, rs);
    axiRd(dfm_pkg::OFF_HIST_CNT, rd, rs);
    m = rd;
    fire(dfm_pkg::ALM_PARAM, 4'h1);
    check({faultIndicator, faultCodeValid}, 2'b00);
    clearBy(2);
    waitIdle();
    @(posedge clk);
    warnCause <= 1'b1;
    fire(dfm_pkg::WARN_TOUGH, 4'h0);
    check({faultIndicator, faultCodeValid}, 2'b10);
    axiRd(dfm_pkg::OFF_STATUS, rd, rs);
    check(rd[1], 1'b1);
    check(rd[4], 1'b1);
    warnCause <= 1'b0;
    repeat (3) @(posedge clk);
    axiRd(dfm_pkg::OFF_STATUS, rd, rs);
    check(rd[1], 1'b0);
    fire(dfm_pkg::WARN_FIRST, 4'h0);
    check({faultIndicator, faultCodeValid}, 2'b10);
    axiRd(dfm_pkg::OFF_HIST_CNT, rd, rs);
    check(rd, m + 1);
    axiWr(dfm_pkg::OFF_HIST_SEL, 32'h0, rs);
    axiRd(dfm_pkg::OFF_HIST_DATA, rd, rs);
    check(rd[11:0], {dfm_pkg::WARN_TOUGH, 4'h0});
    for (i = 0; i < 3; i++) begin
      axiWr(dfm_pkg::OFF_IRQ_CLR, 32'h7, rs);
      alarmCause <= 1'b1;
      fire(dfm_pkg::ALM_UNDERVOLT, 4'h2);
      check({faultIndicator, faultCodeValid, code}, 6'h12);
      check({decelCmd, brakeCmd}, 2'b10);
      @(negedge clk);
      check(irq, 1'b1);
      for (n = 0; n < 40 && brakeCmd !== 1'b1; n++) @(negedge clk);
      check({decelCmd, brakeCmd, code}, 6'h12);
      clearBy(i);
      repeat (6) @(negedge clk);
      check(faultIndicator, 1'b0);
      axiRd(dfm_pkg::OFF_STATUS, rd, rs);
      check({rd[19:8], rd[5:0]}, {dfm_pkg::ALM_UNDERVOLT, 4'h2, 6'h05});
      @(posedge clk);
      alarmCause <= 1'b0;
      clearBy(i);
      waitIdle();
      check({faultCodeValid, code, brakeCmd}, 6'h00);
      axiRd(dfm_pkg::OFF_HIST_DATA, rd, rs);
      check(rd[11:0], {dfm_pkg::ALM_UNDERVOLT, 4'h2});
      axiRd(dfm_pkg::OFF_HIST_CNT, rd, rs);
      check(rd, m + 2 + i);
      axiRd(dfm_pkg::OFF_IRQ_STAT, rd, rs);
      check(rd[2:0], 3'b101);
      axiWr(dfm_pkg::OFF_IRQ_CLR, 32'h7, rs);
      repeat (3) @(negedge clk);
      check(irq, 1'b0);
    end
    for (i = 0; i < 12; i++) begin
      powerCycle();
      num = 8'h10 + 8'($unsigned($random(seed)) % 6);
      det = 4'h1 + 4'($unsigned($random(seed)) % 11);
      if (num == 8'h10) det = det[0] ? 4'h1 : 4'h2;
      m = $unsigned($random(seed)) % 3;
      extUnitPresent <= (m == 2);
      axiWr(dfm_pkg::OFF_CTRL, (m == 0) ? 32'h0 : (m == 1) ? 32'h1 : 32'h11, rs);
      alarmCause <= 1'b1;
      fire(num, det);
      check({faultCodeValid, code}, expCode(num, det, m));
      check({decelCmd, brakeCmd}, (num == 8'h10 && det == 4'h2) ? 2'b10 : 2'b01);
      @(negedge clk);
      check(irq, 1'b0);
      @(posedge clk);
      alarmCause <= 1'b0;
      clearBy(i % 3);
      repeat (6) @(negedge clk);
      check(faultIndicator, num == 8'h10);
    end
    // Frozen block must drop an event seen while enable is low
    powerCycle();
    ceOn <= 1'b0;
    fire(dfm_pkg::ALM_SWITCH, 4'h1);
    check({faultIndicator, brakeCmd}, 2'b10);
    @(posedge clk);
    ceOn <= 1'b1;
    test_done();
  end
endmodule
